// *** rtl/iodcc_pkg.sv ***
// shared constants and types of the console descriptor channel
package iodcc_pkg;
   // word and field layout; descriptor bit n sits at vector index 47-n
   localparam int WORD_W = 48;
   localparam int ADDR_W = 15;
   localparam int CHR_W = 6;
   localparam int CNT_W = 10;
   localparam int UNIT_W = 5;
   localparam int B_INHIBIT = 29;
   localparam int B_BINARY = 26;
   localparam int B_BACKWARD = 25;
   localparam int B_USE_CNT = 24;
   localparam int B_INPUT = 23;
   localparam int B_MEM_ERR = 21;
   localparam int B_KBD_ERR = 19;
   localparam int B_PRN_PAR = 18;
   localparam int B_NOT_READY = 17;
   localparam int B_DESC_PAR = 16;
   localparam int B_UNIT_CONFLICT = 15;
   localparam int UNIT_MSB = 44;
   localparam int CNT_MSB = 39;
   localparam int CHR0_MSB = 47;
   localparam logic [WORD_W-1:0] RES_KEEP_MASK = 48'h1FFF_FFFF_FFFF;
   localparam logic [CHR_W-1:0] GROUP_MARK = 6'h1F;
   localparam logic [2:0] LAST_CHR = 3'h7;
   // fixed core cells
   localparam logic [ADDR_W-1:0] PTR_CELL = 15'h0008;
   localparam logic [ADDR_W-1:0] RES_CELL_BASE = 15'h000C;
   localparam logic [ADDR_W-1:0] ADDR_MAX = 15'h7FFF;
   // register map, byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RES_HI = 4'h8;
   localparam logic [3:0] REG_RES_LO = 4'hC;
   localparam int CTRL_START = 0;
   localparam int CTRL_CLR_DONE = 1;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_PTR = 4'h1,
      ST_DESC = 4'h2,
      ST_CHECK = 4'h3,
      ST_PRD = 4'h4,
      ST_PCH = 4'h5,
      ST_PEND = 4'h6,
      ST_KST = 4'h7,
      ST_KBD = 4'h8,
      ST_KWR = 4'h9,
      ST_RES = 4'hA,
      ST_RWT = 4'hB
   } iodcc_state_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } iodcc_mem_req_t;

   typedef struct packed {
      logic ack;
      logic [WORD_W-1:0] rdata;
      logic par_err;
      logic nxm;
   } iodcc_mem_rsp_t;

   typedef struct packed {
      logic valid;
      logic cr;
      logic [CHR_W-1:0] chr;
   } iodcc_prn_t;

   typedef struct packed {
      logic valid;
      logic par_err;
      logic [CHR_W-1:0] chr;
   } iodcc_kbd_t;
endpackage

// *** rtl/iodcc_channel.sv ***
// console descriptor channel: descriptor decode, print/keyboard moves, result
`timescale 1ns/100ps
module iodcc_channel
   import iodcc_pkg::*;
#(
   parameter int CU_NUM = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // core memory
   output iodcc_mem_req_t mem_req,
   input wire iodcc_mem_rsp_t mem_rsp,
   // unit select and mode to the exchange, unit status from it
   output logic [UNIT_W-1:0] unit_sel,
   input wire logic unit_busy,
   input wire logic unit_claimed,
   input wire logic unit_not_ready,
   input wire logic unit_rewinding,
   output logic fmt_binary,
   output logic tape_backward,
   // console printer
   output iodcc_prn_t prn,
   input wire logic prn_ack,
   // console keyboard
   input wire iodcc_kbd_t kbd,
   input wire logic key_eoi,
   input wire logic key_error,
   input wire logic key_input_req,
   output logic ready_lamp,
   output logic keyboard_request_irq,
   // status
   output logic busy
);

   // refused at elaboration: only four fixed result cells exist
   if (CU_NUM < 1 || CU_NUM > 4) begin : g_bad_cu
      $error("CU_NUM must be 1 to 4");
   end

   localparam logic [ADDR_W-1:0] RES_CELL = RES_CELL_BASE + ADDR_W'(CU_NUM - 1);

   typedef struct packed {
      iodcc_state_t st;
      logic [WORD_W-1:0] desc;
      logic [WORD_W-1:0] res;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wbuf;
      logic [2:0] ci;
      logic [CNT_W-1:0] wcnt;
      logic ran;
      logic gm;
      logic stop;
      iodcc_mem_req_t mem;
      iodcc_prn_t prn;
      logic ready;
      logic irq;
      logic kin_q;
      logic busy;
      logic done;
      logic wait_r;
      logic [31:0] rdata;
   } iodcc_regs_t;

   localparam iodcc_regs_t REGS_RST = '{
      st: ST_IDLE,
      desc: '0,
      res: '0,
      addr: '0,
      wbuf: '0,
      ci: '0,
      wcnt: '0,
      ran: 1'b0,
      gm: 1'b0,
      stop: 1'b0,
      mem: '0,
      prn: '0,
      ready: 1'b0,
      irq: 1'b0,
      kin_q: 1'b0,
      busy: 1'b0,
      done: 1'b0,
      wait_r: 1'b1,
      rdata: '0
   };

   iodcc_regs_t s_r;
   iodcc_regs_t s_nxt;

   logic ack;
   logic bus_wr;
   logic inhibit;
   logic use_cnt;
   logic [CNT_W-1:0] cnt_lim;
   logic [WORD_W-1:0] kword;
   logic [CHR_W-1:0] kchr;
   logic ovf;

   always_comb begin
      s_nxt = s_r;
      ack = s_r.mem.req && mem_rsp.ack;
      bus_wr = avs_write && !s_r.wait_r;
      inhibit = s_r.desc[B_INHIBIT];
      use_cnt = s_r.desc[B_USE_CNT];
      cnt_lim = s_r.desc[CNT_MSB -: CNT_W];
      ovf = (s_r.addr == ADDR_MAX);
      kchr = kbd.chr;
      kword = s_r.wbuf;

      // keyboard request: edge of the momentary key
      s_nxt.kin_q = key_input_req;
      s_nxt.irq = key_input_req && !s_r.kin_q;

      // bus slave: one wait cycle, answer on the next edge
      s_nxt.wait_r = 1'b1;
      if ((avs_read || avs_write) && s_r.wait_r) begin
         s_nxt.wait_r = 1'b0;
         unique case (avs_address)
            REG_STATUS: s_nxt.rdata = {24'h0, s_r.desc[UNIT_MSB -: UNIT_W],
               s_r.ready, s_r.done, s_r.busy};
            REG_RES_HI: s_nxt.rdata = {16'h0, s_r.res[47:32]};
            REG_RES_LO: s_nxt.rdata = s_r.res[31:0];
            default: s_nxt.rdata = 32'h0;
         endcase
      end
      if (bus_wr && avs_address == REG_CTRL && avs_writedata[CTRL_CLR_DONE]) begin
         s_nxt.done = 1'b0;
      end

      // handshakes drop on acceptance
      if (ack) begin
         s_nxt.mem.req = 1'b0;
      end
      if (s_r.prn.valid && prn_ack) begin
         s_nxt.prn.valid = 1'b0;
         s_nxt.prn.cr = 1'b0;
      end

      unique case (s_r.st)
         ST_IDLE: begin
            if (bus_wr && avs_address == REG_CTRL && avs_writedata[CTRL_START]) begin
               s_nxt.busy = 1'b1;
               s_nxt.res = '0;
               s_nxt.ran = 1'b0;
               s_nxt.mem = '{req: 1'b1, we: 1'b0, addr: PTR_CELL, wdata: '0};
               s_nxt.st = ST_PTR;
            end
         end
         ST_PTR: begin
            if (ack) begin
               if (mem_rsp.par_err || mem_rsp.nxm) begin
                  s_nxt.res[B_DESC_PAR] = mem_rsp.par_err;
                  s_nxt.res[B_MEM_ERR] = mem_rsp.nxm;
                  s_nxt.st = ST_RES;
               end else begin
                  s_nxt.mem.req = 1'b1;
                  s_nxt.mem.addr = mem_rsp.rdata[ADDR_W-1:0];
                  s_nxt.st = ST_DESC;
               end
            end
         end
         ST_DESC: begin
            if (ack) begin
               s_nxt.desc = mem_rsp.rdata;
               s_nxt.res = mem_rsp.rdata & RES_KEEP_MASK;
               s_nxt.res[B_DESC_PAR] = mem_rsp.par_err;
               s_nxt.res[B_MEM_ERR] = mem_rsp.nxm;
               s_nxt.addr = mem_rsp.rdata[ADDR_W-1:0];
               s_nxt.wcnt = '0;
               s_nxt.ci = '0;
               s_nxt.wbuf = '0;
               s_nxt.gm = 1'b0;
               s_nxt.stop = 1'b0;
               s_nxt.st = (mem_rsp.par_err || mem_rsp.nxm) ? ST_RES : ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (unit_claimed || unit_rewinding) begin
               s_nxt.res[B_UNIT_CONFLICT] = 1'b1;
               s_nxt.st = ST_RES;
            end else if (unit_not_ready) begin
               s_nxt.res[B_NOT_READY] = 1'b1;
               s_nxt.st = ST_RES;
            end else if (!unit_busy) begin
               s_nxt.ran = 1'b1;
               if (use_cnt && cnt_lim == '0) begin
                  s_nxt.st = ST_RES;
               end else if (s_r.desc[B_INPUT]) begin
                  s_nxt.st = ST_KST;
               end else if (inhibit) begin
                  s_nxt.st = ST_RES;
               end else begin
                  s_nxt.mem = '{req: 1'b1, we: 1'b0, addr: s_r.addr, wdata: '0};
                  s_nxt.st = ST_PRD;
               end
            end
         end
         ST_PRD: begin
            if (ack) begin
               s_nxt.wbuf = mem_rsp.rdata;
               s_nxt.ci = '0;
               s_nxt.wcnt = s_r.wcnt + 1'b1;
               s_nxt.addr = s_r.addr + 1'b1;
               if (mem_rsp.par_err) begin
                  s_nxt.res[B_PRN_PAR] = 1'b1;
               end
               if (ovf || mem_rsp.nxm) begin
                  s_nxt.res[B_MEM_ERR] = 1'b1;
                  s_nxt.stop = 1'b1;
               end
               if (mem_rsp.nxm) begin
                  s_nxt.st = ST_RES;
               end else begin
                  s_nxt.st = ST_PCH;
               end
            end
         end
         ST_PCH: begin
            if (!s_r.prn.valid) begin
               if (s_r.wbuf[CHR0_MSB -: CHR_W] == GROUP_MARK) begin
                  // mark is not printed, only returns the carriage
                  s_nxt.prn = '{valid: 1'b1, cr: 1'b1, chr: '0};
                  s_nxt.st = ST_PEND;
               end else begin
                  s_nxt.prn = '{valid: 1'b1, cr: 1'b0,
                     chr: s_r.wbuf[CHR0_MSB -: CHR_W]};
                  s_nxt.wbuf = s_r.wbuf << CHR_W;
                  s_nxt.ci = s_r.ci + 1'b1;
                  if (s_r.ci == LAST_CHR) begin
                     if (s_r.stop || (use_cnt && s_r.wcnt == cnt_lim)) begin
                        s_nxt.st = ST_PEND;
                     end else begin
                        s_nxt.mem = '{req: 1'b1, we: 1'b0, addr: s_r.addr, wdata: '0};
                        s_nxt.st = ST_PRD;
                     end
                  end
               end
            end
         end
         ST_PEND: begin
            if (!s_r.prn.valid) begin
               s_nxt.st = ST_RES;
            end
         end
         ST_KST: begin
            if (key_eoi) begin
               s_nxt.st = ST_RES;
            end else begin
               s_nxt.ready = 1'b1;
               s_nxt.st = ST_KBD;
            end
         end
         ST_KBD: begin
            if (key_error || key_eoi || kbd.valid) begin
               if (key_error || key_eoi) begin
                  kchr = GROUP_MARK;
               end
               // positions fill from char 0 downward in bit order
               for (int i = 0; i < 8; i++) begin
                  if (s_r.ci == 3'(i)) begin
                     kword[CHR0_MSB - CHR_W*i -: CHR_W] = kchr;
                  end
               end
               if (key_error || (kbd.valid && kbd.par_err && !key_eoi)) begin
                  s_nxt.res[B_KBD_ERR] = 1'b1;
               end
               s_nxt.wbuf = kword;
               s_nxt.ci = s_r.ci + 1'b1;
               s_nxt.gm = key_error || key_eoi;
               if (key_error || key_eoi || s_r.ci == LAST_CHR) begin
                  if (key_error || key_eoi) begin
                     s_nxt.ready = 1'b0;
                  end
                  if (!inhibit) begin
                     s_nxt.mem = '{req: 1'b1, we: 1'b1, addr: s_r.addr, wdata: kword};
                  end
                  s_nxt.st = ST_KWR;
               end
            end
         end
         ST_KWR: begin
            if (ack || inhibit) begin
               s_nxt.addr = s_r.addr + 1'b1;
               s_nxt.wcnt = s_r.wcnt + 1'b1;
               s_nxt.wbuf = '0;
               s_nxt.ci = '0;
               if (ack && mem_rsp.nxm || ovf) begin
                  s_nxt.res[B_MEM_ERR] = 1'b1;
               end
               if (s_r.gm || ovf || (ack && mem_rsp.nxm)
                   || (use_cnt && s_nxt.wcnt == cnt_lim)) begin
                  s_nxt.ready = 1'b0;
                  s_nxt.st = ST_RES;
               end else begin
                  s_nxt.st = ST_KBD;
               end
            end
         end
         ST_RES: begin
            s_nxt.mem.req = 1'b1;
            s_nxt.mem.we = 1'b1;
            s_nxt.mem.addr = RES_CELL;
            s_nxt.mem.wdata = s_r.res;
            if (s_r.ran) begin
               s_nxt.mem.wdata[ADDR_W-1:0] = s_r.addr;
               s_nxt.res[ADDR_W-1:0] = s_r.addr;
            end
            s_nxt.st = ST_RWT;
         end
         ST_RWT: begin
            if (ack) begin
               s_nxt.busy = 1'b0;
               s_nxt.done = 1'b1;
               s_nxt.st = ST_IDLE;
            end
         end
         default: begin
            s_nxt = REGS_RST;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_r <= REGS_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // every output is a field of the state register
   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = s_r.wait_r;
   assign mem_req = s_r.mem;
   assign unit_sel = s_r.desc[UNIT_MSB -: UNIT_W];
   assign fmt_binary = s_r.desc[B_BINARY];
   assign tape_backward = s_r.desc[B_BACKWARD];
   assign prn = s_r.prn;
   assign ready_lamp = s_r.ready;
   assign keyboard_request_irq = s_r.irq;
   assign busy = s_r.busy;

endmodule

// *** verif/iodcc_channel_monitor.sv ***
// port-level assertions for the console descriptor channel
`timescale 1ns/100ps
module iodcc_channel_monitor
   import iodcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // core memory
   input wire iodcc_mem_req_t mem_req,
   input wire iodcc_mem_rsp_t mem_rsp,
   // console
   input wire iodcc_prn_t prn,
   input wire logic prn_ack,
   input wire iodcc_kbd_t kbd,
   input wire logic key_input_req,
   input wire logic ready_lamp,
   input wire logic keyboard_request_irq,
   input wire logic busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_irq_pulse: assert property ($rose(key_input_req) |=> keyboard_request_irq ##1
      !keyboard_request_irq) else $error("irq not a single pulse");
   a_irq_cause: assert property (keyboard_request_irq |->
      $past(key_input_req) && !$past(key_input_req, 2)) else $error("irq without key edge");
   a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
      else $error("answer without request");
   a_mem_hold: assert property (mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable(mem_req))
      else $error("memory request changed before ack");
   a_prn_hold: assert property (prn.valid && !prn_ack |=> prn.valid && $stable(prn))
      else $error("printer item changed before ack");
   a_prn_no_mark: assert property (prn.valid && !prn.cr |-> prn.chr != GROUP_MARK)
      else $error("group mark printed");
   a_lamp_busy: assert property (ready_lamp |-> busy)
      else $error("ready lamp lit while idle");
   c_print: cover property (prn.valid && prn_ack);
   c_key: cover property (kbd.valid && ready_lamp);
   c_store: cover property (mem_req.req && mem_req.we && mem_rsp.ack);
endmodule

// *** verif/iodcc_console_model.sv ***
// console printer and keyboard as a slow human-operated partner
`timescale 1ns/100ps
module iodcc_console_model
   import iodcc_pkg::*;
(
   // clock
   input wire logic clk,
   // printer
   input wire iodcc_prn_t prn,
   output logic prn_ack,
   // keyboard
   output iodcc_kbd_t kbd,
   output logic key_eoi,
   output logic key_error,
   output logic key_input_req
);
   int dly = 3;
   int wcnt = 0;
   logic [6:0] log_q[$];
   initial begin
      prn_ack = 1'b0;
      kbd = '0;
      {key_eoi, key_error, key_input_req} = 3'h0;
   end
   // carriage is slow: each item is taken only after dly cycles
   always @(posedge clk) begin
      prn_ack <= 1'b0;
      if (prn.valid && prn_ack) begin
         log_q.push_back(prn.cr ? 7'h40 : {1'b0, prn.chr});
         wcnt <= 0;
      end else if (prn.valid && wcnt >= dly) begin
         prn_ack <= 1'b1;
      end else if (prn.valid) begin
         wcnt <= wcnt + 1;
      end
   end
   task automatic key(input logic [5:0] c, input logic pe);
      @(posedge clk);
      kbd <= '{valid: 1'b1, par_err: pe, chr: c};
      @(posedge clk);
      // released data lines never keep the last character
      kbd <= '{valid: 1'b0, par_err: 1'b0, chr: ~c};
      repeat (3) @(posedge clk);
   endtask
   task automatic hold(input int k, input int n);
      @(posedge clk);
      if (k == 0) key_eoi <= 1'b1;
      else if (k == 1) key_error <= 1'b1;
      else key_input_req <= 1'b1;
      repeat (n) @(posedge clk);
      {key_eoi, key_error, key_input_req} <= 3'h0;
   endtask
endmodule

// *** verif/tb.sv ***
// self-checking bench of the console descriptor channel
`timescale 1ns/100ps
module tb;
   import iodcc_pkg::*;
   logic clk, nrst, avs_read, avs_write, avs_waitrequest, busy, ready_lamp, irq, prn_ack;
   logic key_eoi, key_error, key_input_req, fmt_binary, tape_backward;
   logic u_busy, u_claimed, u_not_ready, u_rewinding;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [UNIT_W-1:0] unit_sel;
   logic [WORD_W-1:0] mem [0:127];
   logic [WORD_W-1:0] r;
   logic [ADDR_W-1:0] par_addr, nxm_addr;
   iodcc_mem_req_t mem_req;
   iodcc_mem_rsp_t mem_rsp;
   iodcc_prn_t prn;
   iodcc_kbd_t kbd;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   localparam logic [WORD_W-1:0] PD = 48'hBE00_0000_0020;
   localparam logic [WORD_W-1:0] KD = 48'hBE00_0080_0030;
   localparam logic [WORD_W-1:0] SENT = 48'hA5A5_A5A5_A5A5;
   iodcc_channel #(.CU_NUM(1)) i_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
      .mem_rsp(mem_rsp), .unit_sel(unit_sel), .unit_busy(u_busy), .unit_claimed(u_claimed),
      .unit_not_ready(u_not_ready), .unit_rewinding(u_rewinding), .fmt_binary(fmt_binary),
      .tape_backward(tape_backward), .prn(prn), .prn_ack(prn_ack), .kbd(kbd),
      .key_eoi(key_eoi), .key_error(key_error), .key_input_req(key_input_req),
      .ready_lamp(ready_lamp), .keyboard_request_irq(irq), .busy(busy));
   iodcc_console_model i_con (.clk(clk), .prn(prn), .prn_ack(prn_ack), .kbd(kbd),
      .key_eoi(key_eoi), .key_error(key_error), .key_input_req(key_input_req));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // core memory: acks one cycle after each request
   always @(posedge clk) begin
      if (mem_req.req && !mem_rsp.ack) begin
         mem_rsp.ack <= 1'b1;
         mem_rsp.rdata <= mem[mem_req.addr[6:0]];
         mem_rsp.par_err <= (mem_req.addr == par_addr);
         mem_rsp.nxm <= (mem_req.addr == nxm_addr);
         if (mem_req.we) mem[mem_req.addr[6:0]] <= mem_req.wdata;
      end else begin
         mem_rsp <= '0;
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         close_out();
      end
   end
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // chars base, base+1.. up to gm, then group mark, then zero fill
   function automatic logic [WORD_W-1:0] word(input logic [5:0] base, input int gm);
      logic [WORD_W-1:0] w;
      w = '0;
      for (int i = 0; i < 8; i++) w = {w[41:0], i < gm ? 6'(base + i) : i == gm ? GROUP_MARK : 6'h0};
      return w;
   endfunction
   task automatic start_op(input logic [WORD_W-1:0] d);
      mem[8] = 48'h10;
      mem[16] = d;
      mem[12] = '0;
      i_con.log_q.delete();
      bus(1'b1, REG_CTRL, 32'h1);
      repeat (2) @(posedge clk);
   endtask
   task automatic finish_op;
      while (busy !== 1'b0) @(posedge clk);
      r = mem[12];
   endtask
   task automatic t_print;
      mem[32] = word(6'h01, 8);
      mem[33] = word(6'h09, 2);
      u_busy <= 1'b1;
      start_op(PD);
      repeat (20) @(posedge clk);
      check(48'(i_con.log_q.size()), 48'h0);
      check(48'(unit_sel), 48'h1E);
      bus(1'b0, REG_STATUS, 32'h0);
      check(48'(q[7:0]), 48'hF1);
      u_busy <= 1'b0;
      finish_op();
      check(48'(i_con.log_q.size()), 48'hB);
      for (int i = 0; i < 10; i++) check(48'(i_con.log_q[i]), 48'(i + 1));
      check(48'(i_con.log_q[10]), 48'h40);
      check(r, 48'h1E00_0000_0022);
      bus(1'b0, REG_RES_LO, 32'h0);
      check(48'(q), 48'h22);
      bus(1'b0, REG_RES_HI, 32'h0);
      check(48'(q), 48'h1E00);
      bus(1'b0, 4'h2, 32'hFFFF_FFFF);
      check(48'(q), 48'h0);
   endtask
   task automatic t_kbd(input int err);
      mem[48] = SENT;
      start_op(KD);
      for (int n = 0; n < 100 && ready_lamp !== 1'b1; n++) @(posedge clk);
      check(48'(ready_lamp), 48'h1);
      // err 1: error key; err 2: last keystroke arrives with bad parity
      for (int i = 0; i < (err == 1 ? 1 : 3); i++) begin
         i_con.key(6'h11 + 6'(i), err == 2 && i == 2);
      end
      i_con.hold(err == 1, 4);
      finish_op();
      check(48'(ready_lamp), 48'h0);
      check(mem[48], word(6'h11, err == 1 ? 1 : 3));
      check(r, err ? 48'h1E00_0088_0031 : 48'h1E00_0080_0031);
   endtask
   task automatic t_eoi_held;
      mem[48] = SENT;
      fork
         i_con.hold(0, 60);
      join_none
      repeat (2) @(posedge clk);
      start_op(KD);
      finish_op();
      check(mem[48], SENT);
      repeat (60) @(posedge clk);
   endtask
   task automatic t_irq;
      int n;
      n = 0;
      fork
         i_con.hold(2, 3);
      join_none
      repeat (10) begin
         @(posedge clk);
         n += irq;
      end
      check(48'(n), 48'h1);
   endtask
   task automatic t_control;
      logic [WORD_W-1:0] d [3] = '{48'hBE00_2600_0020, 48'hBE00_0100_0020, 48'hBE00_4100_0020};
      i_con.dly = 0;
      for (int k = 0; k < 3; k++) begin
         start_op(d[k]);
         finish_op();
         check(48'(i_con.log_q.size()), k == 2 ? 48'h8 : 48'h0);
         check(48'({fmt_binary, tape_backward}), 48'(d[k][26:25]));
         check(48'(r[47:15]), 48'((d[k] & RES_KEEP_MASK) >> 15));
      end
   endtask
   task automatic t_errors;
      int b [8] = '{17, 15, 15, 16, 21, 16, 18, 21};
      // e 5: pointer parity, e 6: print parity, e 7: address wraps past the top
      mem[127] = word(6'h01, 2);
      for (int e = 0; e < 8; e++) begin
         u_not_ready <= (e == 0);
         u_claimed <= (e == 1);
         u_rewinding <= (e == 2);
         u_busy <= (e == 1 || e == 2);
         par_addr <= (e == 3) ? 15'h0010 : (e == 5) ? PTR_CELL : (e == 6) ? 15'h0020 : 15'h4000;
         nxm_addr <= (e == 4) ? PTR_CELL : 15'h4000;
         start_op(e == 7 ? 48'hBE00_0000_7FFF : PD);
         finish_op();
         check(48'(r[b[e]]), 48'h1);
      end
      {u_not_ready, u_claimed, u_rewinding, u_busy} <= 4'h0;
   endtask
   initial begin
      nrst = 1'b0;
      {avs_read, avs_write} = 2'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      {u_busy, u_claimed, u_not_ready, u_rewinding} = 4'h0;
      par_addr = 15'h7FFF;
      nxm_addr = 15'h7FFF;
      mem_rsp = '0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_print();
      t_kbd(0);
      t_kbd(1);
      t_kbd(2);
      t_eoi_held();
      t_irq();
      t_control();
      t_errors();
      close_out();
   end
endmodule
bind iodcc_channel iodcc_channel_monitor i_mon (.clk(clk), .nrst(nrst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
   .mem_rsp(mem_rsp), .prn(prn), .prn_ack(prn_ack), .kbd(kbd), .key_input_req(key_input_req),
   .ready_lamp(ready_lamp), .keyboard_request_irq(keyboard_request_irq), .busy(busy));
